/* File: rtl/mcui_defs.svh */
// Register offsets, field positions, reset values and fixed read bits of the interrupt unit.
`ifndef MCUI_DEFS_SVH
`define MCUI_DEFS_SVH
`define MCUI_EXTENDED_IRQ_FLAGS_OFF 8'h91
`define MCUI_IE_OFF 8'ha8
`define MCUI_IP_OFF 8'hb8
`define MCUI_WAKEUP_IRQ_CONTROL_OFF 8'hd8
`define MCUI_EIE_OFF 8'he8
`define MCUI_EIP_OFF 8'hf8
`define MCUI_EXTMODE_OFF 8'h8f
`define MCUI_IE_GLOBAL_BIT 7
`define MCUI_WAKEUP_IRQ_CONTROL_WAKE_BIT 3
`define MCUI_EXTMODE_MODE0_BIT 0
`define MCUI_EXTMODE_FLAG0_BIT 1
`define MCUI_EXTMODE_MODE1_BIT 2
`define MCUI_EXTMODE_FLAG1_BIT 3
`define MCUI_IE_FIXED 8'h00
`define MCUI_IP_FIXED 8'h80
`define MCUI_EXTENDED_IRQ_FLAGS_FIXED 8'h08
`define MCUI_WAKEUP_IRQ_CONTROL_FIXED 8'h40
`define MCUI_EIE_FIXED 8'he0
`define MCUI_EIP_FIXED 8'he0
`define MCUI_STD_RST 6'h00
`define MCUI_EXT_RST 5'h00
`define MCUI_FLAG_RST 4'h0
`define MCUI_MODE_RST 2'h0
`define MCUI_NUM_SRC 11
`define MCUI_SRC_EXT0 4'h0
`define MCUI_SRC_EXT1 4'h2
`define MCUI_SRC_NONE 4'hf
`endif

/* File: rtl/mcui_pkg.sv */
// Types shared by the interrupt unit.
package mcui_pkg;
  typedef enum logic [1:0] {
    SVC_NONE,
    SVC_LOW,
    SVC_HIGH,
    SVC_LOW_HIGH
  } mcui_svc_t;

  typedef struct packed {
    logic [7:0] rdata;
    logic req;
    logic [3:0] vec;
    logic ea;
    logic [5:0] std_en;
    logic [5:0] std_pri;
    logic [3:0] ext_flags;
    logic wake_flag;
    logic [4:0] ext_en;
    logic [4:0] ext_pri;
    logic [1:0] ext_mode;
    logic [1:0] ext_edge;
    logic [1:0] pin_prev;
    logic [4:0] src_prev;
    mcui_svc_t svc;
  } mcui_state_t;
endpackage

/* File: rtl/mcui_top.sv */
// Two-level vectored interrupt unit with standard and extended source groups.
//
// Overview of operation
// - External request zero, active low, edge/level.
// - External request one, active low, edge/level.
// - Timer and serial flags are standard sources.
// - Conversion done drives extended source zero.
// - Separate wakeup timer interrupt source.
// - Global enable masks everything when clear.
// - Timer two and serial enables.
// - Low four enable bits, individual sources.
// - Reserved bits read fixed values.
// - Six standard priority bits, low or high.
// - Radio ready two rise sets flag.
// - Radio ready one rise sets flag.
// - SPI byte done sets flag.
// - Conversion done rise sets flag.
// - Software writing one raises interrupt.
// - Standard enable/priority, extended flags/enable/priority.
// - Extended enable bits gate five sources.
// - Wakeup flag persists until software clears.
// - Vector on enable, run until return.
`timescale 1ns/1ps
`include "mcui_defs.svh"

module mcui_top #(
  parameter int NUM_SRC = `MCUI_NUM_SRC
) (
  input wire logic SYS_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic [7:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  output logic [7:0] REG_RDATA_OUT,
  input wire logic EXT_REQUEST_ZERO_N_IN,
  input wire logic EXT_REQUEST_ONE_N_IN,
  input wire logic TIMER_ZERO_OVERFLOW_IN,
  input wire logic TIMER_ONE_OVERFLOW_IN,
  input wire logic TIMER_TWO_OVERFLOW_IN,
  input wire logic TIMER_TWO_EXTERNAL_FLAG_IN,
  input wire logic UART_TX_FLAG_IN,
  input wire logic UART_RX_FLAG_IN,
  input wire logic CONV_DONE_IN,
  input wire logic SPI_BYTE_DONE_IN,
  input wire logic RADIO_READY_ONE_IN,
  input wire logic RADIO_READY_TWO_IN,
  input wire logic WAKEUP_TIMER_IN,
  input wire logic IRQ_ACK_IN,
  input wire logic IRQ_RETI_IN,
  output logic IRQ_REQ_OUT,
  output logic [3:0] IRQ_VECTOR_OUT
);

  mcui_pkg::mcui_state_t state_q;
  mcui_pkg::mcui_state_t state_d;

  // Lowest index wins among equal-priority sources.
  function automatic logic [3:0] pick_lowest(input logic [NUM_SRC-1:0] req);
    logic [3:0] idx;
    idx = `MCUI_SRC_NONE;
    for (int i = NUM_SRC - 1; i >= 0; i--)
    begin
      if (req[i])
      begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction

  logic [NUM_SRC-1:0] pending;
  logic [NUM_SRC-1:0] enables;
  logic [NUM_SRC-1:0] prios;
  logic [NUM_SRC-1:0] active;
  logic [4:0] src_now;
  logic [4:0] src_rise;
  logic [1:0] pin_fall;
  logic wr_extended_irq_flags;
  logic wr_wakeup_irq_control;
  logic wr_mode;
  logic ack_ok;
  logic [3:0] pick_hi;
  logic [3:0] pick_lo;

  always_comb
  begin
    state_d = state_q;
    src_now = {WAKEUP_TIMER_IN, RADIO_READY_TWO_IN, RADIO_READY_ONE_IN,
               SPI_BYTE_DONE_IN, CONV_DONE_IN};
    // Holding a line high sets its flag once; software may clear it meanwhile.
    src_rise = src_now & ~state_q.src_prev;
    pin_fall = state_q.pin_prev & ~{EXT_REQUEST_ONE_N_IN, EXT_REQUEST_ZERO_N_IN};
    wr_extended_irq_flags = REG_WR_IN && (REG_ADDR_IN == `MCUI_EXTENDED_IRQ_FLAGS_OFF);
    wr_wakeup_irq_control = REG_WR_IN && (REG_ADDR_IN == `MCUI_WAKEUP_IRQ_CONTROL_OFF);
    wr_mode = REG_WR_IN && (REG_ADDR_IN == `MCUI_EXTMODE_OFF);
    ack_ok = IRQ_ACK_IN && state_q.req;
    state_d.src_prev = src_now;
    state_d.pin_prev = {EXT_REQUEST_ONE_N_IN, EXT_REQUEST_ZERO_N_IN};

    // Register writes.
    if (REG_WR_IN)
    begin
      case (REG_ADDR_IN)
        `MCUI_IE_OFF:
        begin
          state_d.ea = REG_WDATA_IN[`MCUI_IE_GLOBAL_BIT];
          state_d.std_en = REG_WDATA_IN[5:0];
        end
        `MCUI_IP_OFF:
        begin
          state_d.std_pri = REG_WDATA_IN[5:0];
        end
        `MCUI_EIE_OFF:
        begin
          state_d.ext_en = REG_WDATA_IN[4:0];
        end
        `MCUI_EIP_OFF:
        begin
          state_d.ext_pri = REG_WDATA_IN[4:0];
        end
        `MCUI_EXTMODE_OFF:
        begin
          state_d.ext_mode = {REG_WDATA_IN[`MCUI_EXTMODE_MODE1_BIT],
                              REG_WDATA_IN[`MCUI_EXTMODE_MODE0_BIT]};
        end
        default:
        begin
          state_d.ea = state_q.ea;
        end
      endcase
    end

    // Extended flags: software writes the value, a rising edge sets and wins over a clear.
    if (wr_extended_irq_flags)
    begin
      state_d.ext_flags = REG_WDATA_IN[7:4];
    end
    state_d.ext_flags = state_d.ext_flags | src_rise[3:0];
    if (wr_wakeup_irq_control)
    begin
      state_d.wake_flag = REG_WDATA_IN[`MCUI_WAKEUP_IRQ_CONTROL_WAKE_BIT];
    end
    state_d.wake_flag = state_d.wake_flag | src_rise[4];

    // External edge flags: set on a falling pin, cleared by software or by vectoring.
    if (wr_mode)
    begin
      state_d.ext_edge = {REG_WDATA_IN[`MCUI_EXTMODE_FLAG1_BIT],
                          REG_WDATA_IN[`MCUI_EXTMODE_FLAG0_BIT]};
    end
    if (ack_ok && state_q.vec == `MCUI_SRC_EXT0)
    begin
      state_d.ext_edge[0] = 1'b0;
    end
    if (ack_ok && state_q.vec == `MCUI_SRC_EXT1)
    begin
      state_d.ext_edge[1] = 1'b0;
    end
    state_d.ext_edge = state_d.ext_edge | pin_fall;

    // Priorities are settled here, before service tracking reads them, so no stale value is used.
    prios = {state_d.ext_pri, state_d.std_pri};

    // Service level tracking: return pops the innermost level first.
    if (IRQ_RETI_IN)
    begin
      case (state_q.svc)
        mcui_pkg::SVC_LOW_HIGH: state_d.svc = mcui_pkg::SVC_LOW;
        mcui_pkg::SVC_HIGH: state_d.svc = mcui_pkg::SVC_NONE;
        mcui_pkg::SVC_LOW: state_d.svc = mcui_pkg::SVC_NONE;
        default: state_d.svc = mcui_pkg::SVC_NONE;
      endcase
    end
    else if (ack_ok)
    begin
      case (state_q.svc)
        mcui_pkg::SVC_NONE:
        begin
          state_d.svc = prios[state_q.vec] ? mcui_pkg::SVC_HIGH : mcui_pkg::SVC_LOW;
        end
        mcui_pkg::SVC_LOW: state_d.svc = mcui_pkg::SVC_LOW_HIGH;
        default: state_d.svc = state_q.svc;
      endcase
    end

    // Arbitration works on next-cycle state so an acknowledged request drops at once.
    pending[0] = state_d.ext_mode[0] ? state_d.ext_edge[0] : ~EXT_REQUEST_ZERO_N_IN;
    pending[1] = TIMER_ZERO_OVERFLOW_IN;
    pending[2] = state_d.ext_mode[1] ? state_d.ext_edge[1] : ~EXT_REQUEST_ONE_N_IN;
    pending[3] = TIMER_ONE_OVERFLOW_IN;
    pending[4] = UART_TX_FLAG_IN | UART_RX_FLAG_IN;
    pending[5] = TIMER_TWO_OVERFLOW_IN | TIMER_TWO_EXTERNAL_FLAG_IN;
    pending[9:6] = state_d.ext_flags;
    pending[10] = state_d.wake_flag;
    enables = {state_d.ext_en, state_d.std_en};
    active = pending & enables & {NUM_SRC{state_d.ea}};
    pick_hi = pick_lowest(active & prios);
    pick_lo = pick_lowest(active & ~prios);
    state_d.req = 1'b0;
    state_d.vec = state_q.vec;
    case (state_d.svc)
      mcui_pkg::SVC_NONE:
      begin
        if (pick_hi != `MCUI_SRC_NONE)
        begin
          state_d.req = 1'b1;
          state_d.vec = pick_hi;
        end
        else if (pick_lo != `MCUI_SRC_NONE)
        begin
          state_d.req = 1'b1;
          state_d.vec = pick_lo;
        end
      end
      mcui_pkg::SVC_LOW:
      begin
        if (pick_hi != `MCUI_SRC_NONE)
        begin
          state_d.req = 1'b1;
          state_d.vec = pick_hi;
        end
      end
      default:
      begin
        state_d.req = 1'b0;
      end
    endcase

    // Register reads; unmapped offsets read zero.
    state_d.rdata = 8'h00;
    if (REG_RD_IN)
    begin
      case (REG_ADDR_IN)
        `MCUI_IE_OFF: state_d.rdata = `MCUI_IE_FIXED | {state_q.ea, 1'b0, state_q.std_en};
        `MCUI_IP_OFF: state_d.rdata = `MCUI_IP_FIXED | {2'h0, state_q.std_pri};
        `MCUI_EXTENDED_IRQ_FLAGS_OFF: state_d.rdata = `MCUI_EXTENDED_IRQ_FLAGS_FIXED | {state_q.ext_flags, 4'h0};
        `MCUI_WAKEUP_IRQ_CONTROL_OFF: state_d.rdata = `MCUI_WAKEUP_IRQ_CONTROL_FIXED | {4'h0, state_q.wake_flag, 3'h0};
        `MCUI_EIE_OFF: state_d.rdata = `MCUI_EIE_FIXED | {3'h0, state_q.ext_en};
        `MCUI_EIP_OFF: state_d.rdata = `MCUI_EIP_FIXED | {3'h0, state_q.ext_pri};
        `MCUI_EXTMODE_OFF:
        begin
          state_d.rdata = {4'h0, state_q.ext_edge[1], state_q.ext_mode[1],
                           state_q.ext_edge[0], state_q.ext_mode[0]};
        end
        default: state_d.rdata = 8'h00;
      endcase
    end

    if (!RST_N_IN)
    begin
      state_d.rdata = 8'h00;
      state_d.req = 1'b0;
      state_d.vec = 4'h0;
      state_d.ea = 1'b0;
      state_d.std_en = `MCUI_STD_RST;
      state_d.std_pri = `MCUI_STD_RST;
      state_d.ext_flags = `MCUI_FLAG_RST;
      state_d.wake_flag = 1'b0;
      state_d.ext_en = `MCUI_EXT_RST;
      state_d.ext_pri = `MCUI_EXT_RST;
      state_d.ext_mode = `MCUI_MODE_RST;
      state_d.ext_edge = 2'h0;
      // Pins preset idle and sources preset active, so a line already up at release sets nothing.
      state_d.pin_prev = 2'h3;
      state_d.src_prev = 5'h1f;
      state_d.svc = mcui_pkg::SVC_NONE;
    end
  end

  always_ff @(posedge SYS_CLK_IN)
  begin
    state_q <= state_d;
  end

  assign REG_RDATA_OUT = state_q.rdata;
  assign IRQ_REQ_OUT = state_q.req;
  assign IRQ_VECTOR_OUT = state_q.vec;

  logic [NUM_SRC-1:0] en_q;
  logic [NUM_SRC-1:0] pri_q;
  assign en_q = {state_q.ext_en, state_q.std_en};
  assign pri_q = {state_q.ext_pri, state_q.std_pri};

  default clocking cb @(posedge SYS_CLK_IN);
  endclocking
  default disable iff (!RST_N_IN);

  global_mask_a: assert property (
    !state_q.ea |-> !IRQ_REQ_OUT)
    else $error("Request raised while global enable is clear.");

  source_enabled_a: assert property (
    IRQ_REQ_OUT |-> en_q[IRQ_VECTOR_OUT] && state_q.ea)
    else $error("Request for a source whose enable is clear.");

  conv_rise_a: assert property (
    !CONV_DONE_IN ##1 CONV_DONE_IN |=> state_q.ext_flags[0])
    else $error("Conversion done rise did not set its flag.");

  held_once_a: assert property (
    (!state_q.ext_flags[0] && CONV_DONE_IN && state_q.src_prev[0] && !wr_extended_irq_flags)
    |=> !state_q.ext_flags[0])
    else $error("Held conversion line set its flag again.");

  soft_set_a: assert property (
    (wr_extended_irq_flags && REG_WDATA_IN[7]) |=> state_q.ext_flags[3])
    else $error("Software write of one did not set radio two flag.");

  wake_keep_a: assert property (
    (state_q.wake_flag && !wr_wakeup_irq_control) |=> state_q.wake_flag)
    else $error("Wakeup flag cleared without software.");

  ip_fixed_a: assert property (
    (REG_RD_IN && REG_ADDR_IN == `MCUI_IP_OFF) |=> REG_RDATA_OUT[7:6] == 2'b10)
    else $error("Priority register reserved bits read wrong.");

  preempt_high_a: assert property (
    (state_q.svc == mcui_pkg::SVC_LOW && IRQ_REQ_OUT) |-> pri_q[IRQ_VECTOR_OUT])
    else $error("Low request granted during low service.");

  high_blocks_a: assert property (
    (state_q.svc == mcui_pkg::SVC_HIGH || state_q.svc == mcui_pkg::SVC_LOW_HIGH)
    |-> !IRQ_REQ_OUT)
    else $error("Request raised during high service.");

  level_ext0_a: assert property (
    (!state_q.ext_mode[0] && state_q.ea && state_q.std_en[0] && state_q.std_pri[0]
     && state_q.svc == mcui_pkg::SVC_NONE && !EXT_REQUEST_ZERO_N_IN && !IRQ_ACK_IN
     && !IRQ_RETI_IN && !REG_WR_IN)
    |=> IRQ_REQ_OUT && IRQ_VECTOR_OUT == `MCUI_SRC_EXT0)
    else $error("Level request zero not vectored.");

  // A flag raised without a falling pin would quietly turn edge mode into level mode.
  edge_once_a: assert property (
    (!state_q.ext_edge[0] && !pin_fall[0] && !wr_mode) |=> !state_q.ext_edge[0])
    else $error("External zero edge flag set without a falling pin.");

  edge_clear_a: assert property (
    (ack_ok && state_q.vec == `MCUI_SRC_EXT0 && !pin_fall[0] && !wr_mode)
    |=> !state_q.ext_edge[0])
    else $error("External zero edge flag kept after its vector was taken.");

  edge1_clear_a: assert property (
    (ack_ok && state_q.vec == `MCUI_SRC_EXT1 && !pin_fall[1] && !wr_mode)
    |=> !state_q.ext_edge[1])
    else $error("External one edge flag kept after its vector was taken.");

  extended_irq_flags_fixed_a: assert property (
    (REG_RD_IN && REG_ADDR_IN == `MCUI_EXTENDED_IRQ_FLAGS_OFF) |=> REG_RDATA_OUT[3:0] == 4'h8)
    else $error("Flag register reserved bits read wrong.");

  rdata_idle_a: assert property (
    !REG_RD_IN |=> REG_RDATA_OUT == 8'h00)
    else $error("Read data present without a read strobe.");

  edge_mode_c: cover property (
    state_q.ext_mode[0] && IRQ_REQ_OUT && IRQ_VECTOR_OUT == `MCUI_SRC_EXT0);

  ack_low_c: cover property (
    IRQ_REQ_OUT && IRQ_ACK_IN && state_q.svc == mcui_pkg::SVC_NONE);

  preempt_c: cover property (
    state_q.svc == mcui_pkg::SVC_LOW && IRQ_REQ_OUT && IRQ_ACK_IN);

  soft_radio_c: cover property (
    wr_extended_irq_flags && REG_WDATA_IN[6] ##1 IRQ_REQ_OUT);

  reti_c: cover property (
    state_q.svc == mcui_pkg::SVC_LOW_HIGH && IRQ_RETI_IN);

endmodule

/* File: test/mcui_core_model.sv */
// Processor core model that takes vectored requests and returns on command.
`timescale 1ns/1ps
module mcui_core_model (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic req_in,
  input wire logic [3:0] vec_in,
  input wire logic [1:0] wait_in,
  input wire logic ret_in,
  output logic ack_out,
  output logic reti_out,
  output logic [3:0] vec_out,
  output logic [7:0] cnt_out
);
  logic [1:0] wait_q;
  // A slow core lets a request stand for a few cycles before taking it.
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      ack_out <= 1'b0;
      reti_out <= 1'b0;
      vec_out <= 4'h0;
      cnt_out <= 8'h00;
      wait_q <= 2'h0;
    end
    else
    begin
      ack_out <= 1'b0;
      reti_out <= ret_in;
      wait_q <= 2'h0;
      if (req_in && !ack_out && wait_q == wait_in)
      begin
        ack_out <= 1'b1;
        vec_out <= vec_in;
        cnt_out <= cnt_out + 8'h01;
      end
      else if (req_in && !ack_out)
        wait_q <= wait_q + 2'h1;
    end
  end
endmodule

/* File: test/mcui_top_test.sv */
// Self-checking bench for the interrupt unit with a core model on its request side.
`timescale 1ns/1ps
`include "mcui_defs.svh"
module mcui_top_test;
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] w;
    logic [7:0] e;
  } mcui_row_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [5:0] std_lv = 6'h00;
  logic [4:0] ev = 5'h00;
  logic [1:0] ack_wait = 2'h0;
  logic ret_cmd = 1'b0;
  logic [7:0] rdata;
  logic [7:0] tcnt;
  logic [3:0] vec;
  logic [3:0] tvec;
  logic req;
  logic ack;
  logic reti;
  int err_total = 0;
  int samples_checked = 0;
  mcui_row_t rows [7] = '{
    '{`MCUI_IE_OFF, 8'hff, 8'hbf}, '{`MCUI_IP_OFF, 8'hff, 8'hbf},
    '{`MCUI_EXTENDED_IRQ_FLAGS_OFF, 8'h07, 8'h08}, '{`MCUI_EIE_OFF, 8'h00, 8'he0},
    '{`MCUI_EIP_OFF, 8'h1f, 8'hff}, '{`MCUI_WAKEUP_IRQ_CONTROL_OFF, 8'hb7, 8'h40},
    '{8'h00, 8'hff, 8'h00}};

  always #2 clk = ~clk;

  mcui_top mcui_top_inst (
    .SYS_CLK_IN(clk), .RST_N_IN(rst_n), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
    .REG_WR_IN(wr_s), .REG_RD_IN(rd_s), .REG_RDATA_OUT(rdata),
    .EXT_REQUEST_ZERO_N_IN(~std_lv[0]), .EXT_REQUEST_ONE_N_IN(~std_lv[2]),
    .TIMER_ZERO_OVERFLOW_IN(std_lv[1]), .TIMER_ONE_OVERFLOW_IN(std_lv[3]),
    .TIMER_TWO_OVERFLOW_IN(std_lv[5]), .TIMER_TWO_EXTERNAL_FLAG_IN(1'b0),
    .UART_TX_FLAG_IN(std_lv[4]), .UART_RX_FLAG_IN(1'b0), .CONV_DONE_IN(ev[0]),
    .SPI_BYTE_DONE_IN(ev[1]), .RADIO_READY_ONE_IN(ev[2]), .RADIO_READY_TWO_IN(ev[3]),
    .WAKEUP_TIMER_IN(ev[4]), .IRQ_ACK_IN(ack), .IRQ_RETI_IN(reti), .IRQ_REQ_OUT(req),
    .IRQ_VECTOR_OUT(vec));

  mcui_core_model mcui_core_model_inst (
    .clk_in(clk), .rst_n_in(rst_n), .req_in(req), .vec_in(vec), .wait_in(ack_wait),
    .ret_in(ret_cmd), .ack_out(ack), .reti_out(reti), .vec_out(tvec), .cnt_out(tcnt));

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    samples_checked++;
    if (s !== e)
    begin
      err_total++;
      $display("ERROR at %0t ns: seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    chk(rdata, e);
    // Read data stand for one cycle only and then fall back to zero.
    @(posedge clk);
    #1;
    chk(rdata, 8'h00);
  endtask

  // Waits a bounded time for the core to take a request.
  task automatic take(input logic [3:0] e);
    logic [7:0] c0;
    c0 = tcnt;
    repeat (20) if (tcnt === c0) @(posedge clk);
    #1;
    chk({7'h00, tcnt !== c0}, 8'h01);
    chk({4'h0, tvec}, {4'h0, e});
  endtask

  task automatic quiet();
    logic [7:0] c0;
    c0 = tcnt;
    repeat (8) @(posedge clk);
    #1;
    chk(tcnt, c0);
  endtask

  task automatic ret();
    @(posedge clk);
    ret_cmd <= 1'b1;
    @(posedge clk);
    ret_cmd <= 1'b0;
  endtask

  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
  endtask

  initial
  begin
    do_reset();
    rc(`MCUI_IE_OFF, 8'h00);
    rc(`MCUI_IP_OFF, 8'h80);
    rc(`MCUI_EXTENDED_IRQ_FLAGS_OFF, 8'h08);
    for (int i = 0; i < 7; i++)
    begin
      wr(rows[i].a, rows[i].w);
      rc(rows[i].a, rows[i].e);
    end
    do_reset();
    rc(`MCUI_IE_OFF, 8'h00);
    for (int i = 0; i < 6; i++)
    begin
      @(posedge clk);
      std_lv[i] <= 1'b1;
      wr(`MCUI_IE_OFF, 8'h7f);
      quiet();
      wr(`MCUI_IE_OFF, 8'h80 | (8'h01 << i));
      take(4'(i));
      @(posedge clk);
      std_lv[i] <= 1'b0;
      ret();
    end
    wr(`MCUI_EIE_OFF, 8'h1f);
    wr(`MCUI_EXTENDED_IRQ_FLAGS_OFF, 8'h80);
    take(4'h9);
    rc(`MCUI_EXTENDED_IRQ_FLAGS_OFF, 8'h88);
    ret();
    take(4'h9);
    wr(`MCUI_EXTENDED_IRQ_FLAGS_OFF, 8'h00);
    ret();
    quiet();
    wr(`MCUI_IE_OFF, 8'h00);
    // Lines stay high after the clear, so a level detector would set the flag again.
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk);
      ev[i] <= 1'b1;
      rc(`MCUI_EXTENDED_IRQ_FLAGS_OFF, 8'h08 | (8'h10 << i));
      wr(`MCUI_EXTENDED_IRQ_FLAGS_OFF, 8'h00);
      rc(`MCUI_EXTENDED_IRQ_FLAGS_OFF, 8'h08);
      @(posedge clk);
      ev[i] <= 1'b0;
    end
    wr(`MCUI_IE_OFF, 8'h80);
    @(posedge clk);
    ev[4] <= 1'b1;
    take(4'ha);
    rc(`MCUI_WAKEUP_IRQ_CONTROL_OFF, 8'h48);
    wr(`MCUI_WAKEUP_IRQ_CONTROL_OFF, 8'h40);
    ret();
    quiet();
    wr(`MCUI_IP_OFF, 8'h02);
    wr(`MCUI_IE_OFF, 8'h82);
    ack_wait <= 2'h2;
    wr(`MCUI_EXTENDED_IRQ_FLAGS_OFF, 8'h10);
    take(4'h6);
    @(posedge clk);
    std_lv[1] <= 1'b1;
    take(4'h1);
    wr(`MCUI_EXTENDED_IRQ_FLAGS_OFF, 8'h00);
    std_lv[1] <= 1'b0;
    ret();
    ret();
    quiet();
    // Edge mode: one falling pin gives one request, a pin held low gives no more.
    wr(`MCUI_EXTMODE_OFF, 8'h01);
    rc(`MCUI_EXTMODE_OFF, 8'h01);
    wr(`MCUI_IP_OFF, 8'h01);
    wr(`MCUI_IE_OFF, 8'h81);
    @(posedge clk);
    std_lv[0] <= 1'b1;
    take(4'h0);
    rc(`MCUI_EXTMODE_OFF, 8'h01);
    ret();
    quiet();
    wr(`MCUI_EXTMODE_OFF, 8'h00);
    take(4'h0);
    @(posedge clk);
    std_lv[0] <= 1'b0;
    ret();
    quiet();
    wr(`MCUI_IP_OFF, 8'h00);
    wr(`MCUI_IE_OFF, 8'h8c);
    @(posedge clk);
    std_lv <= 6'h0c;
    take(4'h2);
    @(posedge clk);
    std_lv <= 6'h00;
    ret();
    quiet();
    give_verdict();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    give_verdict();
  end
endmodule
